// [hw/lrc_decoder.sv]
/*
  lrc_decoder: instruction decoder for page, column, modify-read,
  display on/off and the two-byte line/row/partial commands.
  assumes host strobes are one-cycle pulses synchronous to clk, and
  that the busy flag comes from the rest of the controller.
*/
`timescale 1ns/1ps
// Summary of operation
// - upper nibble 1011 loads page pointer 0-15
// - page command never reaches page 16
// - page change leaves display state alone
// - nibble 0001 loads column high bits
// - nibble 0000 loads column low bits
// - each ram write, and each read outside modify-read, bumps column by one
// - page plus column address the ram
// - e0 enters modify-read; reads hold column
// - ee leaves modify-read, restores column
// - display off overrides entire-on and reverse
// - commands still run while display off
// - 010000xx then byte sets start line
// - start line maps to first panel row
// - 010001xx then byte sets first row
// - first row shifts window, ram untouched
// - 010010xx starts partial line selection
// - busy rejects every instruction
// - column wraps to zero after last
module lrc_decoder
  import lrc_pkg::*;
(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      srst,
  input  wire logic      clk_en,
  // host side
  input  wire lrc_host_t host,
  input  wire logic      busy,
  // panel modifiers
  input  wire logic      entire_on,
  input  wire logic      reverse_on,
  // results
  output lrc_addr_t      ram_addr,
  output lrc_disp_t      disp_cfg,
  output logic           modify_read_on,
  output logic           panel_blank,
  output logic           panel_all_on,
  output logic           panel_invert
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  lrc_state_t st_q, st_d;
  logic [3:0] page_q;
  logic [7:0] col_q, col_d, col_save_q;
  logic       mr_q, don_q;
  logic [6:0] start_q, row_q;
  logic [7:0] part_q;

  wire ok      = clk_en && !busy;
  wire cmd_wr  = ok && host.wr && !host.cmd_data_select;
  wire dat_wr  = ok && host.wr && host.cmd_data_select;
  wire dat_rd  = ok && host.rd && host.cmd_data_select;
  wire [7:0] b = host.host_data_bus;
  wire is_par  = cmd_wr && (st_q != LRC_ST_IDLE);
  wire is_one  = cmd_wr && (st_q == LRC_ST_IDLE);
  wire do_page = is_one && b[7:4] == OP_PAGE;
  wire do_chi  = is_one && b[7:4] == OP_COL_HI;
  wire do_clo  = is_one && b[7:4] == OP_COL_LO;
  wire do_mrs  = is_one && b == OP_MR_SET;
  wire do_mrc  = is_one && b == OP_MR_CLR;
  wire do_disp = is_one && b[7:1] == OP_DISP;
  wire bump    = dat_wr || (dat_rd && !mr_q);
  wire [7:0] col_inc = (col_q >= COL_LAST) ? 8'h00
                                           : col_q + 8'h01;

  always_comb begin
    col_d = col_q;
    if (do_chi) begin
      col_d = {b[3:0], col_q[3:0]};
    end else if (do_clo) begin
      col_d = {col_q[7:4], b[3:0]};
    end else if (do_mrc && mr_q) begin
      col_d = col_save_q;
    end else if (bump) begin
      col_d = col_inc;
    end
  end

  always_comb begin
    st_d = st_q;
    if (is_par) begin
      st_d = LRC_ST_IDLE;
    end else if (is_one) begin
      case (b[7:2])
        OP_START:    st_d = LRC_ST_START;
        OP_FIRSTROW: st_d = LRC_ST_ROW;
        OP_PARTIAL:  st_d = LRC_ST_PART;
        default:     st_d = LRC_ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= LRC_ST_IDLE;
      col_q <= COL_RST;
    end else if (clk_en) begin
      st_q <= st_d;
      col_q <= col_d;
    end
  end

  // page has 4 bits, so 16 is unreachable from here
  always_ff @(posedge clk) begin
    if (srst) begin
      page_q <= PAGE_RST;
    end else if (do_page) begin
      page_q <= b[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mr_q       <= 1'b0;
      col_save_q <= COL_RST;
    end else if (do_mrs) begin
      mr_q       <= 1'b1;
      col_save_q <= col_q;
    end else if (do_mrc) begin
      mr_q       <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      don_q <= 1'b0;
    end else if (do_disp) begin
      don_q <= b[0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      start_q <= LINE_RST;
      row_q   <= LINE_RST;
      part_q  <= PART_RST;
    end else if (is_par) begin
      case (st_q)
        LRC_ST_START: start_q <= b[6:0];
        LRC_ST_ROW:   row_q   <= b[6:0];
        LRC_ST_PART:  part_q  <= b;
        default:      part_q  <= part_q;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign ram_addr.page_field   = page_q;
  assign ram_addr.column_field = col_q;
  assign disp_cfg.display_on_bit   = don_q;
  assign disp_cfg.start_line_field = start_q;
  assign disp_cfg.first_row_field  = row_q;
  assign disp_cfg.partial_field    = part_q;
  assign modify_read_on = mr_q;
  assign panel_blank  = !don_q;
  assign panel_all_on = don_q && entire_on;
  assign panel_invert = don_q && reverse_on;

endmodule // lrc_decoder

// [hw/lrc_pkg.sv]
/*
  lrc_pkg: constants and carrier types for the lcd ram addressing
  command decoder. assumes nothing beyond a systemverilog compiler.
*/
package lrc_pkg;

  // ---------------------------------------------------------------
  // command encodings
  // ---------------------------------------------------------------
  localparam logic [3:0] OP_PAGE      = 4'hb;
  localparam logic [3:0] OP_COL_HI    = 4'h1;
  localparam logic [3:0] OP_COL_LO    = 4'h0;
  localparam logic [7:0] OP_MR_SET    = 8'he0;
  localparam logic [7:0] OP_MR_CLR    = 8'hee;
  localparam logic [6:0] OP_DISP      = 7'h57;
  localparam logic [5:0] OP_START     = 6'h10;
  localparam logic [5:0] OP_FIRSTROW  = 6'h11;
  localparam logic [5:0] OP_PARTIAL   = 6'h12;

  // ---------------------------------------------------------------
  // field positions, limits and reset values
  // ---------------------------------------------------------------
  localparam int         COL_HI_POS   = 4;
  localparam logic [7:0] COL_LAST     = 8'h9f;
  localparam logic [3:0] PAGE_RST     = 4'h0;
  localparam logic [7:0] COL_RST      = 8'h00;
  localparam logic [6:0] LINE_RST     = 7'h00;
  localparam logic [7:0] PART_RST     = 8'h00;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LRC_ST_IDLE  = 2'b00,
    LRC_ST_START = 2'b01,
    LRC_ST_ROW   = 2'b10,
    LRC_ST_PART  = 2'b11
  } lrc_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       cmd_data_select;
    logic [7:0] host_data_bus;
  } lrc_host_t;

  typedef struct packed {
    logic [3:0] page_field;
    logic [7:0] column_field;
  } lrc_addr_t;

  typedef struct packed {
    logic       display_on_bit;
    logic [6:0] start_line_field;
    logic [6:0] first_row_field;
    logic [7:0] partial_field;
  } lrc_disp_t;

endpackage

// [tb/lrc_host_model.sv]
/* host model: drives the instruction bus.
   assumes strobes launched at the falling clk edge. */
`timescale 1ns/1ps
module lrc_host_model
  import lrc_pkg::*;
(
  // clock
  input  wire logic clk,
  // host bus
  output lrc_host_t host
);
  initial host = '{1'b0, 1'b0, 1'b0, 8'hff};
  // one strobe, bus inverted once released
  task automatic xfer(input logic w, cds, input logic [7:0] v);
    @(negedge clk) host <= '{w, !w, cds, v};
    @(negedge clk) host <= '{1'b0, 1'b0, cds, ~v};
  endtask
endmodule // lrc_host_model

// [tb/lrc_decoder_checker.sv]
/* checker for lrc_decoder ports.
   assumes one clk domain and srst. */
`timescale 1ns/1ps
module lrc_decoder_checker
  import lrc_pkg::*;
(
  // watched ports
  input wire logic      clk,
  input wire logic      srst,
  input wire logic      clk_en,
  input wire lrc_host_t host,
  input wire logic      busy,
  input wire lrc_addr_t ram_addr,
  input wire lrc_disp_t disp_cfg,
  input wire logic      modify_read_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic       pend_q;
  logic [7:0] sv_q;
  wire logic [7:0] b = host.host_data_bus;
  wire logic [7:0] col = ram_addr.column_field;
  wire logic tk = clk_en & !busy;
  wire logic c = tk & host.wr & !host.cmd_data_select;
  wire logic ci = c & !pend_q;
  wire logic d = tk & host.cmd_data_select & (host.wr | !modify_read_on);
  always_ff @(posedge clk) begin
    if (srst) pend_q <= 1'b0;
    else if (c) pend_q <= !pend_q && b[7:4] == 4'h4 && b[3:2] != 2'b11;
    if (ci && b == OP_MR_SET && !modify_read_on) sv_q <= col;
  end
  AST_PAGE: assert property (ci && b[7:4] == OP_PAGE |=>
    ram_addr.page_field == $past(b[3:0]) && $stable(disp_cfg))
    else $error("page load wrong");
  AST_COLH: assert property (ci && b[7:4] == OP_COL_HI |=>
    col == {$past(b[3:0]), $past(col[3:0])}) else $error("col hi wrong");
  AST_COLL: assert property (ci && b[7:4] == OP_COL_LO |=>
    col == {$past(col[7:4]), $past(b[3:0])}) else $error("col lo wrong");
  AST_INC: assert property (d && (host.wr | host.rd) && col < COL_LAST
    |=> col == $past(col) + 8'h01) else $error("no increment");
  AST_WRAP: assert property (d && (host.wr | host.rd) && col >= COL_LAST
    |=> col == 8'h00) else $error("no wrap");
  AST_MRH: assert property (tk && host.rd && host.cmd_data_select
    && modify_read_on |=> $stable(col)) else $error("read moved col");
  AST_MRC: assert property (ci && b == OP_MR_CLR && modify_read_on
    |=> col == sv_q && !modify_read_on) else $error("no restore");
  AST_BUSY: assert property (!tk |=> $stable(ram_addr)
    && $stable(disp_cfg)) else $error("busy not ignored");
endmodule // lrc_decoder_checker
bind lrc_decoder lrc_decoder_checker u_chk (.clk(clk), .srst(srst),
  .clk_en(clk_en), .host(host), .busy(busy), .ram_addr(ram_addr),
  .disp_cfg(disp_cfg), .modify_read_on(modify_read_on));

// [tb/lrc_decoder_tb_top.sv]
/* testbench for lrc_decoder with host model.
   assumes lrc_pkg and a 100 mhz clk. */
`timescale 1ns/1ps
module lrc_decoder_tb_top;
  import lrc_pkg::*;
  logic      clk, srst, clk_en, busy, ent, rev, mr, pb, pa, pi;
  lrc_host_t host;
  lrc_addr_t ra;
  lrc_disp_t dc;
  int        error_cnt, comparisons;
  lrc_decoder DUT (.clk(clk), .srst(srst), .clk_en(clk_en), .host(host),
    .busy(busy), .entire_on(ent), .reverse_on(rev), .ram_addr(ra),
    .disp_cfg(dc), .modify_read_on(mr), .panel_blank(pb),
    .panel_all_on(pa), .panel_invert(pi));
  lrc_host_model HM (.clk(clk), .host(host));
  // ----
  // tasks
  // ----
  task automatic chk(input string n, input logic [39:0] s, e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic cmd(input logic [7:0] v);
    HM.xfer(1'b1, 1'b0, v);
  endtask
  task automatic final_report;
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_page;
    lrc_disp_t d0;
    d0 = dc;
    for (int p = 0; p < 16; p++) begin
      cmd({OP_PAGE, 4'(p)});
      chk("page", 40'(ra.page_field), 40'(p));
    end
    chk("disp", 40'(dc), 40'(d0));
  endtask
  task automatic t_col;
    cmd(8'h19);
    cmd(8'h0f);
    chk("col", 40'(ra.column_field), 40'(COL_LAST));
    HM.xfer(1'b1, 1'b1, 8'h5a);
    chk("wrap", 40'(ra.column_field), 40'h0);
    cmd(8'h13);
    cmd(8'h05);
  endtask
  task automatic t_mr;
    cmd(OP_MR_SET);
    HM.xfer(1'b0, 1'b1, 8'h00);
    chk("mr rd", 40'({mr, ra.column_field}), 40'h135);
    HM.xfer(1'b1, 1'b1, 8'h00);
    chk("mr wr", 40'(ra.column_field), 40'h36);
    cmd(OP_MR_CLR);
    chk("mr end", 40'({mr, ra.column_field}), 40'h035);
    HM.xfer(1'b0, 1'b1, 8'h00);
    chk("rd", 40'(ra.column_field), 40'h36);
  endtask
  task automatic t_disp;
    ent = 1'b1;
    rev = 1'b1;
    cmd({OP_DISP, 1'b1});
    chk("on", 40'({pb, pa, pi}), 40'h3);
    cmd({OP_DISP, 1'b0});
    cmd(8'hb7);
    chk("off", 40'({pb, pa, pi, ra.page_field}), 40'h47);
  endtask
  task automatic t_two;
    cmd(8'h43);
    HM.xfer(1'b1, 1'b1, 8'h00);
    cmd(8'hb5);
    chk("line", 40'({ra.page_field, dc.start_line_field}),
        40'h3b5);
    cmd(8'h46);
    cmd(8'h7f);
    chk("row", 40'(dc.first_row_field), 40'h7f);
    cmd(8'h49);
    cmd(8'h80);
    chk("part", 40'(dc.partial_field), 40'h80);
  endtask
  task automatic t_busy;
    busy = 1'b1;
    cmd(8'hb2);
    busy = 1'b0;
    clk_en = 1'b0;
    cmd(8'hb2);
    clk_en = 1'b1;
    chk("busy", 40'(ra.page_field), 40'h7);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #20us;
    error_cnt++;
    final_report;
  end
  initial begin
    {srst, clk_en, busy, ent, rev} = 5'b11000;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    chk("rst", 40'({pb, mr, ra, dc}), 40'h1000000000);
    t_page;
    t_col;
    t_mr;
    t_disp;
    t_two;
    t_busy;
    final_report;
  end
endmodule // lrc_decoder_tb_top
